//--- hw/tmr_pkg.sv
package tmr_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] REF_CTRL_ADDR = 8'h40;
  localparam int SRC_MSB = 7;
  localparam int SRC_LSB = 6;
  localparam int MRST_BIT = 5;
  localparam int LOOP_MSB = 3;
  localparam int LOOP_LSB = 0;
  localparam int NUM_PORTS = 4;
  localparam logic [1:0] SRC_RESET = 2'h0;
  localparam logic [3:0] LOOP_RESET = 4'h0;
  localparam logic [7:0] AD_RESET = 8'h00;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int MRST_TIME_NS = 128;
  localparam int MRST_CYCLES = (MRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] WIDTH_CNT_RESET = 4'h0;

  // receive reference pulse width code: 1, 2, 4 or 8 cycles
  function automatic logic [3:0] rx_width_cycles(input logic [1:0] code);
    case (code)
      2'h0: rx_width_cycles = 4'h1;
      2'h1: rx_width_cycles = 4'h2;
      2'h2: rx_width_cycles = 4'h4;
      default: rx_width_cycles = 4'h8;
    endcase
  endfunction : rx_width_cycles

endpackage : tmr_pkg

//--- hw/tmr_sync.sv
`timescale 1ns/1ns
module tmr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // ****************************************
  // two-stage synchroniser
  // ****************************************
  // first stage is read by the second stage only
  logic [W-1:0] meta_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_r <= INIT;
      sync_out <= INIT;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : tmr_sync

//--- hw/tmr_top.sv
`timescale 1ns/1ns
module tmr_top #(
  parameter int MRST_HOLD = tmr_pkg::MRST_CYCLES
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ub_ale,
  input wire logic ub_cs_n,
  input wire logic ub_rd_n,
  input wire logic ub_wr_n,
  input wire logic [7:0] ub_ad_in,
  output logic [7:0] ub_ad_out,
  output logic ub_ad_oe_n,
  input wire logic tx_marker_ref_in_n,
  input wire logic [3:0] rx_marker_det,
  input wire logic [1:0] rx_ref_width,
  output logic rx_marker_ref_out_n,
  output logic [3:0] tx_marker_ins,
  output logic master_rst
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic ale_s;
  logic cs_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic tx_ref_n_s;
  logic [7:0] ad_s;

  tmr_sync #(.W(5), .INIT(5'h0f)) u_sync_ctl (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in({ub_ale, ub_cs_n, ub_rd_n, ub_wr_n, tx_marker_ref_in_n}),
    .sync_out({ale_s, cs_n_s, rd_n_s, wr_n_s, tx_ref_n_s})
  );

  tmr_sync #(.W(8), .INIT(8'h00)) u_sync_ad (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in(ub_ad_in),
    .sync_out(ad_s)
  );

  // ****************************************
  // utility bus slave
  // ****************************************
  logic [7:0] addr_r;
  logic [7:0] wdata_r;
  logic wr_n_d_r;
  logic cs_n_d_r;
  logic tx_ref_n_d_r;
  logic hit;
  logic write_evt;
  logic rd_act;
  logic [1:0] src_r;
  logic [3:0] loop_r;
  logic [7:0] rdata;

  assign hit = (addr_r == tmr_pkg::REF_CTRL_ADDR);
  // chip select may drop with the strobe, so the delayed copy is used
  assign write_evt = wr_n_s && !wr_n_d_r && !cs_n_d_r && hit && !master_rst;
  assign rd_act = !cs_n_s && !rd_n_s && hit;
  // reset bit is write-only and reads as not-in-reset
  assign rdata = {src_r, 1'b0, 1'b0, loop_r};

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      addr_r <= tmr_pkg::AD_RESET;
      wdata_r <= tmr_pkg::AD_RESET;
      wr_n_d_r <= 1'b1;
      cs_n_d_r <= 1'b1;
      tx_ref_n_d_r <= 1'b1;
    end else begin
      if (ale_s) begin
        addr_r <= ad_s;
      end
      if (!wr_n_s) begin
        wdata_r <= ad_s;
      end
      wr_n_d_r <= wr_n_s;
      cs_n_d_r <= cs_n_s;
      tx_ref_n_d_r <= tx_ref_n_s;
    end
  end

  // other addresses belong to other blocks, so the bus is left undriven
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ub_ad_out <= tmr_pkg::AD_RESET;
      ub_ad_oe_n <= 1'b1;
    end else begin
      ub_ad_out <= rd_act ? rdata : tmr_pkg::AD_RESET;
      ub_ad_oe_n <= !rd_act;
    end
  end

  // ****************************************
  // control register and master reset
  // ****************************************
  logic [3:0] mrst_cnt_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst || master_rst) begin
      src_r <= tmr_pkg::SRC_RESET;
      loop_r <= tmr_pkg::LOOP_RESET;
    end else if (write_evt) begin
      if (wdata_r[tmr_pkg::MRST_BIT]) begin
        src_r <= tmr_pkg::SRC_RESET;
        loop_r <= tmr_pkg::LOOP_RESET;
      end else begin
        src_r <= wdata_r[tmr_pkg::SRC_MSB:tmr_pkg::SRC_LSB];
        loop_r <= wdata_r[tmr_pkg::LOOP_MSB:tmr_pkg::LOOP_LSB];
      end
    end
  end

  // bit clears itself once the hold count runs out
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      master_rst <= 1'b0;
      mrst_cnt_r <= 4'h0;
    end else if (write_evt && wdata_r[tmr_pkg::MRST_BIT]) begin
      master_rst <= 1'b1;
      mrst_cnt_r <= 4'(MRST_HOLD - 1);
    end else if (mrst_cnt_r != 4'h0) begin
      mrst_cnt_r <= mrst_cnt_r - 4'h1;
    end else begin
      master_rst <= 1'b0;
    end
  end

  // ****************************************
  // timing marker routing
  // ****************************************
  logic tx_ref_fall;
  logic rx_start;
  logic [3:0] width_cnt_r;
  logic [3:0] width_cnt_nxt;

  assign tx_ref_fall = tx_ref_n_d_r && !tx_ref_n_s;
  assign rx_start = rx_marker_det[src_r] && !master_rst;

  // a new marker restarts the pulse; pulse widths need the 4-bit count
  always_comb begin
    if (rx_start) begin
      width_cnt_nxt = tmr_pkg::rx_width_cycles(rx_ref_width);
    end else if (width_cnt_r != 4'h0) begin
      width_cnt_nxt = width_cnt_r - 4'h1;
    end else begin
      width_cnt_nxt = 4'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      width_cnt_r <= tmr_pkg::WIDTH_CNT_RESET;
      rx_marker_ref_out_n <= 1'b1;
    end else begin
      width_cnt_r <= width_cnt_nxt;
      rx_marker_ref_out_n <= (width_cnt_nxt == 4'h0);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || master_rst) begin
      tx_marker_ins <= 4'h0;
    end else begin
      for (int n = 0; n < tmr_pkg::NUM_PORTS; n++) begin
        // looped port ignores the transmit reference entirely
        tx_marker_ins[n] <= loop_r[n] ? rx_marker_det[n] : tx_ref_fall;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_src_pulse;
    @(posedge ref_clk) disable iff (sys_rst)
    (rx_marker_det[src_r] && !master_rst) |=> !rx_marker_ref_out_n;
  endproperty
  a_src_pulse: assert property (p_src_pulse) else $error("selected port marker gave no pulse");

  property p_mrst_self_clear;
    @(posedge ref_clk) disable iff (sys_rst)
    (write_evt && wdata_r[tmr_pkg::MRST_BIT]) |=> master_rst ##MRST_HOLD !master_rst;
  endproperty
  a_mrst_self_clear: assert property (p_mrst_self_clear) else $error("master reset not held then cleared");

  property p_mrst_clears_ctrl;
    @(posedge ref_clk) disable iff (sys_rst)
    master_rst |=> (loop_r == 4'h0) && (src_r == 2'h0) && (tx_marker_ins == 4'h0);
  endproperty
  a_mrst_clears_ctrl: assert property (p_mrst_clears_ctrl) else $error("master reset left state set");

  property p_tx_ref_drive;
    @(posedge ref_clk) disable iff (sys_rst)
    (tx_ref_fall && !master_rst) |=> ((tx_marker_ins & ~$past(loop_r)) == ~$past(loop_r));
  endproperty
  a_tx_ref_drive: assert property (p_tx_ref_drive) else $error("unlooped port missed reference marker");

  property p_loop_copy;
    @(posedge ref_clk) disable iff (sys_rst)
    !master_rst |=> ((tx_marker_ins & $past(loop_r)) == ($past(rx_marker_det) & $past(loop_r)));
  endproperty
  a_loop_copy: assert property (p_loop_copy) else $error("looped port not copying received markers");

  property p_reset_values;
    @(posedge ref_clk) disable iff (sys_rst)
    $past(sys_rst) |-> (loop_r == 4'h0) && (src_r == 2'h0) && !master_rst;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("control register reset value wrong");

  property p_pulse_cause;
    @(posedge ref_clk) disable iff (sys_rst)
    $fell(rx_marker_ref_out_n) |-> $past(rx_start);
  endproperty
  a_pulse_cause: assert property (p_pulse_cause) else $error("reference pulse without selected marker");

endmodule : tmr_top

//--- test/tmr_partner.sv
`timescale 1ns/1ns
// ****************************************
// far side timing logic
// ****************************************
module tmr_partner (
  input wire logic ref_clk,
  output logic tx_marker_ref_in_n,
  output logic [3:0] rx_marker_det,
  output logic [1:0] rx_ref_width
);
  initial begin
    tx_marker_ref_in_n = 1'b1;
    rx_marker_det = 4'h0;
    // widest pulse, safe when a port is looped
    rx_ref_width = 2'h3;
  end

  // held low several cycles so the synchroniser sees it
  task automatic tx_pulse();
    @(posedge ref_clk) #1 tx_marker_ref_in_n = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 tx_marker_ref_in_n = 1'b1;
  endtask : tx_pulse

  task automatic rx_pulse(input int p);
    @(posedge ref_clk) #1 rx_marker_det[p] = 1'b1;
    @(posedge ref_clk) #1 rx_marker_det = 4'h0;
  endtask : rx_pulse
endmodule : tmr_partner

//--- test/tb.sv
`timescale 1ns/1ns
// ****************************************
// bench
// ****************************************
module tb;
  logic ref_clk, sys_rst, ub_ale, ub_cs_n, ub_rd_n, ub_wr_n;
  logic [7:0] ub_ad_in, ub_ad_out, rd_v;
  logic ub_ad_oe_n, tx_n, out_n, master_rst;
  logic [3:0] det, ins;
  logic [1:0] width;
  int errors = 0, comparisons = 0, cycles = 0, mcnt = 0, lows = 0;
  int tcnt [4];
  // written value, value read back
  logic [7:0] rows [3][2] = '{'{8'hC5, 8'hC5}, '{8'h5A, 8'h4A}, '{8'h8F, 8'h8F}};

  tmr_top #(.MRST_HOLD(4)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .ub_ale(ub_ale), .ub_cs_n(ub_cs_n),
    .ub_rd_n(ub_rd_n), .ub_wr_n(ub_wr_n), .ub_ad_in(ub_ad_in), .ub_ad_out(ub_ad_out), .ub_ad_oe_n(ub_ad_oe_n),
    .tx_marker_ref_in_n(tx_n), .rx_marker_det(det), .rx_ref_width(width), .rx_marker_ref_out_n(out_n),
    .tx_marker_ins(ins), .master_rst(master_rst));
  tmr_partner far (.ref_clk(ref_clk), .tx_marker_ref_in_n(tx_n), .rx_marker_det(det), .rx_ref_width(width));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (master_rst === 1'b1) mcnt <= mcnt + 1;
    if (out_n === 1'b0) lows <= lows + 1;
    for (int i = 0; i < 4; i++) if (ins[i] === 1'b1) tcnt[i] <= tcnt[i] + 1;
    if (cycles == 5000) begin
      errors++;
      stop_test();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic addr(input logic [7:0] a);
    @(posedge ref_clk) #1 ub_ale = 1'b1;
    ub_ad_in = a;
    repeat (4) @(posedge ref_clk);
    #1 ub_ale = 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : addr

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr(a);
    #1 ub_cs_n = 1'b0;
    ub_wr_n = 1'b0;
    ub_ad_in = d;
    repeat (5) @(posedge ref_clk);
    #1 ub_wr_n = 1'b1;
    ub_cs_n = 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask : wr

  // 8'hee marks a cycle the device did not drive
  task automatic rd(input logic [7:0] a);
    addr(a);
    #1 ub_ad_in = ~a;
    ub_cs_n = 1'b0;
    ub_rd_n = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1 rd_v = (ub_ad_oe_n === 1'b0) ? ub_ad_out : 8'hEE;
    ub_rd_n = 1'b1;
    ub_cs_n = 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask : rd

  task automatic stop_test();
    if (errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  initial begin
    sys_rst = 1'b1;
    ub_ale = 1'b0;
    ub_cs_n = 1'b1;
    ub_rd_n = 1'b1;
    ub_wr_n = 1'b1;
    ub_ad_in = 8'h00;
    repeat (10) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    check({ub_ad_oe_n, out_n, master_rst, 1'b0, ins}, 8'hC0);
    rd(8'h40);
    check(rd_v, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(8'h40, rows[i][0]);
      rd(8'h40);
      check(rd_v, rows[i][1]);
    end
    // unmapped address: no drive, no effect
    wr(8'h41, 8'hFF);
    rd(8'h41);
    check(rd_v, 8'hEE);
    rd(8'h40);
    check(rd_v, 8'h8F);
    // narrow widths only while nothing is looped
    wr(8'h40, 8'h80);
    for (int w = 0; w < 4; w++) begin
      #1 far.rx_ref_width = 2'(w);
      lows = 0;
      tcnt = '{0, 0, 0, 0};
      far.rx_pulse(2);
      repeat (12) @(posedge ref_clk);
      #1 check(8'(lows), 8'h01 << w);
      check(8'(tcnt[2]), 8'h00);
    end
    wr(8'h40, 8'h84);
    tcnt = '{0, 0, 0, 0};
    far.rx_pulse(2);
    repeat (12) @(posedge ref_clk);
    #1 check(8'(tcnt[2]), 8'h01);
    lows = 0;
    far.rx_pulse(1);
    repeat (12) @(posedge ref_clk);
    #1 check(8'(lows), 8'h00);
    tcnt = '{0, 0, 0, 0};
    far.tx_pulse();
    repeat (8) @(posedge ref_clk);
    #1 for (int i = 0; i < 4; i++) check(8'(tcnt[i]), (i == 2) ? 8'h00 : 8'h01);
    mcnt = 0;
    wr(8'h40, 8'hE3);
    check(8'(mcnt), 8'h04);
    rd(8'h40);
    check(rd_v, 8'h00);
    // reset in mid-run after a non-default value
    wr(8'h40, 8'hC5);
    @(posedge ref_clk) #1 sys_rst = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    check({ub_ad_oe_n, out_n, master_rst, 1'b0, ins}, 8'hC0);
    rd(8'h40);
    check(rd_v, 8'h00);
    lows = 0;
    far.rx_pulse(0);
    repeat (12) @(posedge ref_clk);
    #1 check(8'(lows), 8'h08);
    stop_test();
  end
endmodule : tb
